// ==== core/t8d_pkg.sv ====
/*
 * Constants shared by the eight-bit transmit/demodulate counter:
 * register indices, field positions, reset values and filter lengths.
 * Assumes a 32-bit AXI4-Lite bus, one register per aligned word.
 */
package t8d_pkg;

   // ****************************************************************
   // Register map (index; byte address is four times the index)
   // ****************************************************************
   localparam logic [3:0] IDX_COUNTER_CONTROL = 4'h0;
   localparam logic [3:0] IDX_SHARED_CONTROL  = 4'h1;
   localparam logic [3:0] IDX_LOW_CAPTURE     = 4'h2;
   localparam logic [3:0] IDX_HIGH_CAPTURE    = 4'h3;
   localparam logic [3:0] IDX_LOW_HOLD        = 4'h4;
   localparam logic [3:0] IDX_HIGH_HOLD       = 4'h5;
   localparam int         AXI_ADDR_W          = 8;

   // ****************************************************************
   // Counter control fields
   // ****************************************************************
   localparam int CC_RUN      = 7;
   localparam int CC_SINGLE   = 6;
   localparam int CC_TIMEOUT  = 5;
   localparam int CC_RATE_HI  = 4;
   localparam int CC_RATE_LO  = 3;
   localparam int CC_CAP_IE   = 2;
   localparam int CC_TMO_IE   = 1;

   // ****************************************************************
   // Shared control fields
   // ****************************************************************
   localparam int SC_MODE_HI  = 7;
   localparam int SC_MODE_LO  = 6;
   localparam int SC_ROUTE    = 5;
   localparam int SC_SUB_HI   = 3;
   localparam int SC_SUB_LO   = 2;
   localparam int SC_RISE     = 1;
   localparam int SC_FALL     = 0;

   // ****************************************************************
   // Values
   // ****************************************************************
   localparam logic [7:0] CNT_ALL_ONES  = 8'hff;
   localparam logic [7:0] CNT_ONE       = 8'h01;
   localparam logic [7:0] CNT_ZERO      = 8'h00;
   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam logic [1:0] SUB_NORMAL    = 2'h0;
   localparam logic [1:0] SUB_PINGPONG  = 2'h1;
   localparam logic [1:0] SUB_FORCE_LO  = 2'h2;
   localparam logic [1:0] SUB_FORCE_HI  = 2'h3;
   localparam logic [3:0] FILT_NONE     = 4'h1;
   localparam logic [3:0] FILT_SHORT    = 4'h4;
   localparam logic [3:0] FILT_LONG     = 4'h8;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// ==== core/t8d_glitch_filter.sv ====
/*
 * Glitch filter for the demodulator input: a new level is passed on
 * only after it has been seen for the selected number of cycles.
 * Assumes the raw input is synchronous to aclk.
 */
module t8d_glitch_filter
   import t8d_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       raw,
   input  wire logic [1:0] filt_sel,
   output logic            clean
);

   logic [3:0] run_len;
   logic [3:0] need;

   // ****************************************************************
   // Filter length; reserved code behaves as no filter
   // ****************************************************************
   always_comb begin
      case (filt_sel)
         2'h1:    need = FILT_SHORT;
         2'h2:    need = FILT_LONG;
         default: need = FILT_NONE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_len <= 4'h0;
         clean   <= 1'b0;
      end else if (raw == clean) begin
         run_len <= 4'h0;
      end else if (run_len + 4'h1 >= need) begin
         run_len <= 4'h0;
         clean   <= raw;
      end else begin
         run_len <= run_len + 4'h1;
      end
   end

endmodule

// ==== core/t8d_timer.sv ====
/*
 * Eight-bit down counter with transmit and demodulation modes, behind an
 * AXI4-Lite slave. Holds control, hold and capture registers.
 * Assumes inputs synchronous to aclk; wide counter output comes in as a pin.
 */
// How it works
// - Mode field zero means transmit, else demodulate
// - Transmit: route bit picks port or combined output
// - Demodulate: route bit picks port2 or comparator input
// - Comparator source captures also pulse external line two
// - Enable sets start level, loads matching hold (all ones in demodulate)
// - Start level bit: 0 low, 1 high
// - Single pass: reach zero, halt, toggle, flag, optional irq
// - Modulo-N: first terminal count toggles without irq
// - Later terminal counts toggle, flag, optional irq
// - Reload low hold if output 0, else high
// - Hold writes take effect at next reload
// - Initial count zero wraps to all ones
// - Falling edge captures high, rising captures low
// - Capture sets edge flag and optional irq
// - Capture reloads counter with all ones
// - Demodulate zero: timeout flag, optional irq, restart ones
// - Control bit two enables capture interrupt
module t8d_timer
   import t8d_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  port2_bit0_input,
   input  wire logic                  comparator_input_pin,
   input  wire logic                  port_normal_value,
   input  wire logic                  sixteen_bit_counter_out,
   output logic                       combined_output_pin,
   output logic                       eight_bit_wave_output,
   output logic                       timeout_irq,
   output logic                       capture_irq,
   output logic                       external_irq_line_two
);

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   logic                  run, single, tmo_flag, cap_ie, tmo_ie;
   logic [1:0]            rate, mode, submode, init_lvl, edge_flag;
   logic                  route_sel;
   logic [7:0]            low_hold, high_hold, low_cap, high_cap;
   logic [7:0]            count;
   logic                  first_tc;
   logic [2:0]            pre_cnt;
   logic                  aw_got, w_got;
   logic [AXI_ADDR_W-1:0] aw_addr;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic                  filt, filt_d;

   // ****************************************************************
   // Decode and events
   // ****************************************************************
   logic       demod, wr_en, wr_c0, wr_c1, start, tick, at_one;
   logic       tx_tc, dm_tmo, rise, fall, cap_ev, tmo_set;
   logic [2:0] rate_mask;
   logic [3:0] wr_idx, rd_idx;
   logic [7:0] rd_byte;
   logic       rd_ok, wr_ok;

   assign demod  = |mode;
   assign wr_idx = aw_addr[5:2];
   assign rd_idx = s_axi_araddr[5:2];
   assign wr_ok  = (aw_addr[1:0] == 2'h0) && (aw_addr[AXI_ADDR_W-1:6] == '0)
                   && (wr_idx <= IDX_HIGH_HOLD);
   assign wr_en  = aw_got && w_got && !s_axi_bvalid;
   assign wr_c0  = wr_en && wr_ok && w_strb[0] && (wr_idx == IDX_COUNTER_CONTROL);
   assign wr_c1  = wr_en && wr_ok && w_strb[0] && (wr_idx == IDX_SHARED_CONTROL);
   assign start  = wr_c0 && w_data[CC_RUN] && !run;
   assign at_one = (count == CNT_ONE);

   always_comb begin
      case (rate)
         2'h1:    rate_mask = 3'h1;
         2'h2:    rate_mask = 3'h3;
         2'h3:    rate_mask = 3'h7;
         default: rate_mask = 3'h0;
      endcase
   end

   assign tick    = run && ((pre_cnt & rate_mask) == rate_mask);
   assign tx_tc   = tick && !demod && at_one;
   assign dm_tmo  = tick && demod && at_one;
   assign rise    = run && demod && filt && !filt_d;
   assign fall    = run && demod && !filt && filt_d;
   assign cap_ev  = rise || fall;
   // Capture outranks a timeout landing in the same cycle
   assign tmo_set = (tx_tc && (single || !first_tc)) || (dm_tmo && !cap_ev);

   // ****************************************************************
   // Demodulator input: source select, filter, edge history
   // ****************************************************************
   t8d_glitch_filter u_filter (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .raw      (route_sel ? comparator_input_pin : port2_bit0_input),
      .filt_sel (demod ? submode : 2'h0),
      .clean    (filt)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) filt_d <= 1'b0;
      else          filt_d <= filt;
   end

   // ****************************************************************
   // Counter control register
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run    <= 1'b0;
         single <= 1'b0;
         rate   <= 2'h0;
         cap_ie <= 1'b0;
         tmo_ie <= 1'b0;
      end else begin
         if (wr_c0) begin
            run    <= w_data[CC_RUN];
            single <= w_data[CC_SINGLE];
            rate   <= w_data[CC_RATE_HI:CC_RATE_LO];
            cap_ie <= w_data[CC_CAP_IE];
            tmo_ie <= w_data[CC_TMO_IE];
         end else if (tx_tc && single) begin
            run <= 1'b0;
         end
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) tmo_flag <= 1'b0;
      else tmo_flag <= tmo_set || (tmo_flag && !(wr_c0 && w_data[CC_TIMEOUT]));
   end

   // ****************************************************************
   // Shared control register; low bits are levels or edge flags
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode      <= 2'h0;
         route_sel <= 1'b0;
         submode   <= SUB_NORMAL;
         init_lvl  <= 2'h0;
      end else if (wr_c1) begin
         mode      <= w_data[SC_MODE_HI:SC_MODE_LO];
         route_sel <= w_data[SC_ROUTE];
         submode   <= w_data[SC_SUB_HI:SC_SUB_LO];
         if (!demod) init_lvl <= w_data[SC_RISE:SC_FALL];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_flag <= 2'h0;
      end else begin
         edge_flag[1] <= rise || (edge_flag[1] && !(wr_c1 && demod && w_data[SC_RISE]));
         edge_flag[0] <= fall || (edge_flag[0] && !(wr_c1 && demod && w_data[SC_FALL]));
      end
   end

   // Hold values are only sampled at start and at reload time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_hold  <= REG_RESET;
         high_hold <= REG_RESET;
      end else if (wr_en && wr_ok && w_strb[0]) begin
         if (wr_idx == IDX_LOW_HOLD)  low_hold  <= w_data[7:0];
         if (wr_idx == IDX_HIGH_HOLD) high_hold <= w_data[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_cap  <= REG_RESET;
         high_cap <= REG_RESET;
      end else begin
         if (rise) low_cap  <= count;
         if (fall) high_cap <= count;
      end
   end

   // ****************************************************************
   // Prescaler and counter
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn || start) pre_cnt <= 3'h0;
      else if (run)          pre_cnt <= pre_cnt + 3'h1;
   end

   // A loaded count of one hits terminal count at once; software avoids it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count    <= CNT_ZERO;
         eight_bit_wave_output <= 1'b0;
         first_tc <= 1'b0;
      end else if (start) begin
         eight_bit_wave_output <= init_lvl[1];
         first_tc <= 1'b1;
         if (demod)            count <= CNT_ALL_ONES;
         else if (init_lvl[1]) count <= high_hold;
         else                  count <= low_hold;
      end else if (demod) begin
         if (cap_ev)      count <= CNT_ALL_ONES;
         else if (dm_tmo) count <= CNT_ALL_ONES;
         else if (tick)   count <= count - CNT_ONE;
      end else if (tx_tc) begin
         eight_bit_wave_output <= !eight_bit_wave_output;
         first_tc <= 1'b0;
         if (single)                     count <= CNT_ZERO;
         else if (eight_bit_wave_output) count <= low_hold;
         else                            count <= high_hold;
      end else if (tick) begin
         count <= count - CNT_ONE;
      end
   end

   // ****************************************************************
   // Pins and interrupt pulses
   // ****************************************************************
   logic wide_out;
   always_comb begin
      case (submode)
         SUB_FORCE_LO: wide_out = 1'b0;
         SUB_FORCE_HI: wide_out = 1'b1;
         default:      wide_out = sixteen_bit_counter_out;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         combined_output_pin   <= 1'b0;
         timeout_irq           <= 1'b0;
         capture_irq           <= 1'b0;
         external_irq_line_two <= 1'b0;
      end else begin
         if (!demod && route_sel)
            combined_output_pin <= eight_bit_wave_output | wide_out;
         else
            combined_output_pin <= port_normal_value;
         timeout_irq           <= tmo_set && tmo_ie;
         capture_irq           <= cap_ev && cap_ie;
         external_irq_line_two <= cap_ev && route_sel;
      end
   end

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   always_comb begin
      case (rd_idx)
         IDX_COUNTER_CONTROL:
            rd_byte = {run, single, tmo_flag, rate, cap_ie, tmo_ie, 1'b0};
         IDX_SHARED_CONTROL:
            rd_byte = {mode, route_sel, 1'b0, submode, demod ? edge_flag : init_lvl};
         IDX_LOW_CAPTURE:  rd_byte = low_cap;
         IDX_HIGH_CAPTURE: rd_byte = high_cap;
         IDX_LOW_HOLD:     rd_byte = low_hold;
         IDX_HIGH_HOLD:    rd_byte = high_hold;
         default:          rd_byte = REG_RESET;
      endcase
   end
   assign rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[AXI_ADDR_W-1:6] == '0)
                  && (rd_idx <= IDX_HIGH_HOLD);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= '0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got        <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got        <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_byte};
         s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_fall_seen;
      fall;
   endsequence
   sequence s_tc_later;
      tx_tc && !single && !first_tc && tmo_ie;
   endsequence

   a_start_level: assert property (start |=> eight_bit_wave_output == $past(init_lvl[1]))
      else $error("start level not applied");
   a_start_load: assert property (start && !demod |=>
      count == ($past(init_lvl[1]) ? $past(high_hold) : $past(low_hold)))
      else $error("start count wrong");
   a_single_halt: assert property (tx_tc && single && !wr_c0 |=>
      !run && count == CNT_ZERO && tmo_flag ##1 count == CNT_ZERO)
      else $error("single pass did not halt");
   a_first_quiet: assert property (tx_tc && !single && first_tc |=> !timeout_irq)
      else $error("first terminal count raised irq");
   a_modn_irq: assert property (s_tc_later |=> timeout_irq && tmo_flag)
      else $error("terminal count irq missing");
   a_modn_reload: assert property (tx_tc && !single |=> count ==
      ($past(eight_bit_wave_output) ? $past(low_hold) : $past(high_hold)))
      else $error("reload from wrong hold");
   a_wrap_zero: assert property (tick && !demod && count == CNT_ZERO && !start
      |=> count == CNT_ALL_ONES)
      else $error("zero did not wrap");
   a_capture_high: assert property (s_fall_seen |=>
      high_cap == $past(count) && edge_flag[0] && count == CNT_ALL_ONES
      && capture_irq == $past(cap_ie))
      else $error("falling capture wrong");
   a_capture_irq: assert property (cap_ev && cap_ie |=> capture_irq ##1 !capture_irq)
      else $error("capture irq not a pulse");
   a_demod_timeout: assert property (dm_tmo && !cap_ev && !start |=>
      tmo_flag && count == CNT_ALL_ONES)
      else $error("demod timeout wrong");
   a_line_two: assert property (cap_ev && !route_sel |=> !external_irq_line_two)
      else $error("line two raised from port source");
   a_port_route: assert property (!demod && !route_sel ##1 !demod && !route_sel |->
      combined_output_pin == $past(port_normal_value))
      else $error("port value not routed");

endmodule

// ==== sim/t8d_timer_tb.sv ====
/*
 * Self-checking bench for the eight-bit counter: register access,
 * single pass, modulo-N at every rate, demodulator captures.
 * Assumes t8d_timer and t8d_pkg; bready and rready are held high.
 */
module t8d_timer_tb
   import t8d_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic        aclk, aresetn, awv, awr, wv, wr_rdy, bv, bready, arv, arr, rv, rready;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdat;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        p2, cmp, pnv, wide, comb, wave, tirq, cirq, ext;
   int          err_total, checks_done;

   t8d_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .port2_bit0_input(p2),
      .comparator_input_pin(cmp), .port_normal_value(pnv), .sixteen_bit_counter_out(wide),
      .combined_output_pin(comb), .eight_bit_wave_output(wave), .timeout_irq(tirq),
      .capture_irq(cirq), .external_irq_line_two(ext));

   always #5 aclk = ~aclk;

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tmo();
      err_total++;
      $display("ERROR wait expected handshake seen timeout");
      end_of_test();
   endtask

   // Both channels offered together; each released once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awa <= a;
      wd <= {24'h00_0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awv && awr)
            awv <= 1'b0;
         if (wv && wr_rdy)
            wv <= 1'b0;
      end while (!bv && n < 50);
      if (n >= 50)
         tmo();
      chk("bresp", er, bresp);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [7:0] d);
      int n;
      n = 0;
      ara <= a;
      arv <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arv && arr)
            arv <= 1'b0;
      end while (!rv && n < 50);
      if (n >= 50)
         tmo();
      chk("rresp", er, rresp);
      d = rdat[7:0];
   endtask

   task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, RESP_OKAY, d);
      chk(nm, e, d);
   endtask

   task automatic wait_pulse(ref logic s, output int n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (s !== 1'b1 && n < 300);
      if (n >= 300)
         tmo();
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs();
      logic [7:0] d;
      rc("control reset", 8'h00, 8'h00);
      rc("shared reset", 8'h04, 8'h00);
      wr(8'h10, 8'h5a, RESP_OKAY);
      rc("low hold", 8'h10, 8'h5a);
      wr(8'h18, 8'h11, RESP_SLVERR);
      rd(8'h18, RESP_SLVERR, d);
      chk("unmapped data", 8'h00, d);
      $display("test regs done");
   endtask

   task automatic t_single();
      int n;
      pnv <= 1'b1;
      wr(8'h10, 8'h04, RESP_OKAY);
      wr(8'h04, 8'h00, RESP_OKAY);
      wr(8'h00, 8'hc2, RESP_OKAY);
      @(posedge aclk);
      chk("start level low", 1'b0, wave);
      chk("combined normal", 1'b1, comb);
      wait_pulse(tirq, n);
      chk("pass length", 1'b1, n >= 3 && n <= 7);
      chk("wave after pass", 1'b1, wave);
      rc("control after pass", 8'h00, 8'h62);
      wr(8'h00, 8'h22, RESP_OKAY);
      rc("timeout cleared", 8'h00, 8'h02);
      // Zero hold wraps; written while stopped, never one
      wr(8'h10, 8'h00, RESP_OKAY);
      wr(8'h00, 8'h80, RESP_OKAY);
      repeat (20) @(posedge aclk);
      chk("wrap keeps level", 1'b0, wave);
      wr(8'h00, 8'h00, RESP_OKAY);
      $display("test single done");
   endtask

   task automatic t_modulo();
      int t[3];
      int k, n, irqs;
      logic last;
      wr(8'h10, 8'h03, RESP_OKAY);
      wr(8'h14, 8'h05, RESP_OKAY);
      wr(8'h04, 8'h22, RESP_OKAY);
      for (int r = 0; r < 4; r++) begin
         wr(8'h00, {1'b1, 2'b00, r[1:0], 3'b010}, RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk("start level high", 1'b1, wave);
         chk("combined timer", 1'b1, comb);
         last = 1'b1;
         k = 0;
         irqs = 0;
         n = 0;
         while (k < 3 && n < 400) begin
            @(posedge aclk);
            n++;
            if (tirq === 1'b1)
               irqs++;
            if (wave !== last) begin
               t[k] = n;
               k++;
               last = wave;
            end
         end
         if (n >= 400)
            tmo();
         repeat (2) begin
            @(posedge aclk);
            if (tirq === 1'b1)
               irqs++;
         end
         chk("low interval", 3 << r, t[1] - t[0]);
         chk("high interval", 5 << r, t[2] - t[1]);
         chk("timeout irqs", 2, irqs);
         wr(8'h00, 8'h00, RESP_OKAY);
      end
      $display("test modulo done");
   endtask

   task automatic t_demod();
      logic [7:0] d;
      int n;
      wr(8'h04, 8'h40, RESP_OKAY);
      wr(8'h00, 8'h84, RESP_OKAY);
      repeat (5) @(posedge aclk);
      p2 <= 1'b1;
      wait_pulse(cirq, n);
      repeat (10) @(posedge aclk);
      p2 <= 1'b0;
      wait_pulse(cirq, n);
      rc("edge flags", 8'h04, 8'h43);
      rd(8'h0c, RESP_OKAY, d);
      chk("high capture", 1'b1, d >= 8'hf0 && d <= 8'hf6);
      rd(8'h08, RESP_OKAY, d);
      chk("low capture", 1'b1, d >= 8'hf0 && d < 8'hff);
      wr(8'h04, 8'h42, RESP_OKAY);
      rc("rise cleared", 8'h04, 8'h41);
      wr(8'h04, 8'h60, RESP_OKAY);
      cmp <= 1'b1;
      wait_pulse(ext, n);
      rc("comparator flag", 8'h04, 8'h63);
      wr(8'h00, 8'h00, RESP_OKAY);
      $display("test demod done");
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awv, wv, arv, p2, cmp, pnv, wide} = '0;
      awa = '0;
      ara = '0;
      wd = '0;
      wstrb = 4'hf;
      bready = 1'b1;
      rready = 1'b1;
      err_total = 0;
      checks_done = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_single();
      t_modulo();
      t_demod();
      end_of_test();
   end
endmodule
